// ### logic/nor_host_pkg.sv
// Package of constants and types for the parallel NOR flash host controller
package nor_host_pkg;

	// ****************************************
	// Array geometry
	// ****************************************
	localparam int unsigned WORD_COUNT   = 4194304;
	localparam int unsigned BYTE_COUNT   = 8388608;
	localparam int          WORD_ADDR_W  = 22;
	localparam int          BYTE_ADDR_W  = 23;
	localparam int          DATA_W       = 16;

	// ****************************************
	// Command words and unlock addresses (fixed package constants)
	// ****************************************
	localparam logic [11:0] UNLOCK_ADDR_A = 12'h555;
	localparam logic [11:0] UNLOCK_ADDR_B = 12'h2AA;
	localparam logic [7:0]  UNLOCK_DATA_A = 8'hAA;
	localparam logic [7:0]  UNLOCK_DATA_B = 8'h55;
	localparam logic [7:0]  CMD_PROGRAM   = 8'hA0;
	localparam logic [7:0]  CMD_ERASE_SET = 8'h80;
	localparam logic [7:0]  CMD_SECT_ERS  = 8'h30;
	localparam logic [7:0]  CMD_BYPASS_EN = 8'h20;
	localparam logic [7:0]  CMD_BYPASS_EX = 8'h90;
	localparam logic [7:0]  CMD_BYPASS_EX2 = 8'h00;
	localparam logic [7:0]  CMD_SUSPEND   = 8'hB0;
	localparam logic [7:0]  CMD_RESUME    = 8'h30;
	localparam logic [7:0]  CMD_RESET     = 8'hF0;

	// ****************************************
	// Timing, in ns, and derived cycle counts at 200 MHz
	// ****************************************
	localparam int          CLK_PERIOD_NS = 5;
	localparam int          WRITE_LOW_NS  = 35;
	localparam int          WRITE_HIGH_NS = 20;
	localparam int          READ_ACC_NS   = 70;
	localparam int          RESET_LOW_NS  = 500;
	localparam logic [7:0]  WRITE_LOW_CYC  = 8'((WRITE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [7:0]  WRITE_HIGH_CYC = 8'((WRITE_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [7:0]  READ_ACC_CYC   = 8'((READ_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [7:0]  RESET_LOW_CYC  = 8'((RESET_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

	// ****************************************
	// Operations requested by the user side
	// ****************************************
	typedef enum logic [3:0] {
		OP_READ        = 4'h0,
		OP_PROGRAM     = 4'h1,
		OP_SECT_ERASE  = 4'h2,
		OP_BYPASS_ON   = 4'h3,
		OP_BYPASS_OFF  = 4'h4,
		OP_SUSPEND     = 4'h5,
		OP_RESUME      = 4'h6,
		OP_SOFT_RESET  = 4'h7,
		OP_HW_RESET    = 4'h8,
		OP_RAW_WRITE   = 4'h9
	} op_t;

	typedef struct packed {
		op_t                     op;
		logic [BYTE_ADDR_W-1:0]  addr;
		logic [DATA_W-1:0]       data;
	} req_t;

	// Pins toward the flash
	typedef struct packed {
		logic                    chip_sel_n;
		logic                    write_n;
		logic                    out_en_n;
		logic                    reset_dev_n;
		logic                    byte_mode_n;
		logic                    edge_guard_fast_program_pin;
		logic [BYTE_ADDR_W-1:0]  addr;
		logic [DATA_W-1:0]       dq_out;
		logic                    dq_oe;
	} pins_t;

	// Controller states, Gray along the usual path
	typedef enum logic [3:0] {
		ST_IDLE    = 4'b0000,
		ST_WR_LOW  = 4'b0001,
		ST_WR_HIGH = 4'b0011,
		ST_NEXT    = 4'b0010,
		ST_POLL    = 4'b0110,
		ST_RD      = 4'b0111,
		ST_RST     = 4'b0101,
		ST_DONE    = 4'b0100
	} state_t;

	localparam logic [2:0] SEQ_MAX = 3'h6;

endpackage : nor_host_pkg

// ### logic/nor_cycle_timer.sv
// Down-counting timer used to pace bus strobes
`timescale 1ns/1ps
module nor_cycle_timer #(
	parameter int W = 8
) (
	input  wire logic         clk,
	input  wire logic         reset_n,
	input  wire logic         load,
	input  wire logic [W-1:0] value,
	output logic              expired
);
	logic [W-1:0] count;
	logic [W-1:0] next_count;

	// ****************************************
	// Count down to zero after each load
	// ****************************************
	always_comb begin
		next_count = count;
		if (load) begin
			next_count = value;
		end else if (count != '0) begin
			next_count = count - W'(1);
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			count <= '0;
		end else begin
			count <= next_count;
		end
	end

	// Expiry from the count alone, so a reload on expiry forms no loop
	assign expired = (count == '0);
endmodule : nor_cycle_timer

// ### logic/nor_host_ctrl.sv
// Host controller driving an asynchronous parallel NOR flash over its pins
`timescale 1ns/1ps
// Functional notes
// - A byte-mode input selects an 8-bit bus where the model allows it, otherwise 16-bit.
// - Every command goes out as an ordinary bus write cycle whose address and data the flash latches.
// - Program and erase start only by command sequences, and completion is seen by polling together with the idle output.
// - In unlock bypass a word program takes two write cycles instead of four.
// - Erase suspend pauses the erase, lets other sectors be used, and resume finishes it.
// - Program suspend pauses the program, lets other sectors be read, and resume finishes it.
module nor_host_ctrl #(
	parameter bit           BYTE_CAPABLE = 1'b1,
	parameter logic [15:0]  POLL_LIMIT   = 16'hFFFF
) (
	input  wire logic                               clk,
	input  wire logic                               reset_n,
	input  wire logic                               byte_mode,
	input  wire logic                               write_guard,
	input  wire logic                               req_valid,
	output logic                                    req_ready,
	input  wire nor_host_pkg::req_t                 req,
	output logic                                    done,
	output logic                                    fail,
	output logic [nor_host_pkg::DATA_W-1:0]         rd_data,
	output logic                                    bypass_on,
	output nor_host_pkg::pins_t                     pins,
	input  wire logic [nor_host_pkg::DATA_W-1:0]    dq_in,
	input  wire logic                               operation_idle_output
);
	nor_host_pkg::state_t              state;
	nor_host_pkg::state_t              next_state;
	nor_host_pkg::req_t                cur;
	nor_host_pkg::req_t                next_cur;
	logic [2:0]                        step;
	logic [2:0]                        next_step;
	logic [2:0]                        steps;
	logic [15:0]                       polls;
	logic [15:0]                       next_polls;
	logic                              next_bypass_on;
	logic                              next_done;
	logic                              next_fail;
	logic [nor_host_pkg::DATA_W-1:0]   next_rd_data;
	logic                              last_toggle;
	logic                              next_last_toggle;
	logic                              polled_once;
	logic                              next_polled_once;
	nor_host_pkg::pins_t               next_pins;
	logic                              tmr_load;
	logic [7:0]                        tmr_value;
	logic                              tmr_expired;
	logic [11:0]                       cyc_addr;
	logic [7:0]                        cyc_data;
	logic                              byte_eff;

	// ****************************************
	// Strobe pacing timer
	// ****************************************
	nor_cycle_timer #(.W(8)) i_nor_cycle_timer (
		.clk     (clk),
		.reset_n (reset_n),
		.load    (tmr_load),
		.value   (tmr_value),
		.expired (tmr_expired)
	);

	// Byte mode only on models that have it
	assign byte_eff  = BYTE_CAPABLE && byte_mode;
	assign req_ready = (state == nor_host_pkg::ST_IDLE);

	// ****************************************
	// Number of bus writes per operation
	// ****************************************
	always_comb begin
		case (cur.op)
			nor_host_pkg::OP_PROGRAM:    steps = bypass_on ? 3'd2 : 3'd4;
			nor_host_pkg::OP_SECT_ERASE: steps = bypass_on ? 3'd2 : 3'd6;
			nor_host_pkg::OP_BYPASS_ON:  steps = 3'd3;
			nor_host_pkg::OP_BYPASS_OFF: steps = 3'd2;
			default:                     steps = 3'd1;
		endcase
	end

	// ****************************************
	// Address and data of each command write
	// ****************************************
	always_comb begin
		cyc_addr = nor_host_pkg::UNLOCK_ADDR_A;
		cyc_data = nor_host_pkg::UNLOCK_DATA_A;
		case (cur.op)
			nor_host_pkg::OP_PROGRAM, nor_host_pkg::OP_SECT_ERASE: begin
				if (bypass_on) begin
					cyc_data = (cur.op == nor_host_pkg::OP_PROGRAM) ?
						nor_host_pkg::CMD_PROGRAM : nor_host_pkg::CMD_ERASE_SET;
					if (step == 3'd1) begin
						cyc_addr = cur.addr[11:0];
						cyc_data = (cur.op == nor_host_pkg::OP_PROGRAM) ?
							cur.data[7:0] : nor_host_pkg::CMD_SECT_ERS;
					end
				end else begin
					case (step)
						3'd1, 3'd4: begin
							cyc_addr = nor_host_pkg::UNLOCK_ADDR_B;
							cyc_data = nor_host_pkg::UNLOCK_DATA_B;
						end
						3'd2: cyc_data = (cur.op == nor_host_pkg::OP_PROGRAM) ?
							nor_host_pkg::CMD_PROGRAM : nor_host_pkg::CMD_ERASE_SET;
						3'd3: begin
							cyc_addr = (cur.op == nor_host_pkg::OP_PROGRAM) ?
								cur.addr[11:0] : nor_host_pkg::UNLOCK_ADDR_A;
							cyc_data = (cur.op == nor_host_pkg::OP_PROGRAM) ?
								cur.data[7:0] : nor_host_pkg::UNLOCK_DATA_A;
						end
						3'd5: begin
							cyc_addr = cur.addr[11:0];
							cyc_data = nor_host_pkg::CMD_SECT_ERS;
						end
						default: ;
					endcase
				end
			end
			nor_host_pkg::OP_BYPASS_ON: begin
				if (step == 3'd1) begin
					cyc_addr = nor_host_pkg::UNLOCK_ADDR_B;
					cyc_data = nor_host_pkg::UNLOCK_DATA_B;
				end else if (step == 3'd2) begin
					cyc_data = nor_host_pkg::CMD_BYPASS_EN;
				end
			end
			nor_host_pkg::OP_BYPASS_OFF: begin
				cyc_addr = cur.addr[11:0];
				cyc_data = (step == 3'd0) ? nor_host_pkg::CMD_BYPASS_EX : nor_host_pkg::CMD_BYPASS_EX2;
			end
			nor_host_pkg::OP_SUSPEND: begin
				cyc_addr = cur.addr[11:0];
				cyc_data = nor_host_pkg::CMD_SUSPEND;
			end
			nor_host_pkg::OP_RESUME: begin
				cyc_addr = cur.addr[11:0];
				cyc_data = nor_host_pkg::CMD_RESUME;
			end
			nor_host_pkg::OP_SOFT_RESET: cyc_data = nor_host_pkg::CMD_RESET;
			default: begin
				cyc_addr = cur.addr[11:0];
				cyc_data = cur.data[7:0];
			end
		endcase
	end

	// ****************************************
	// Main sequencer
	// ****************************************
	always_comb begin
		next_state       = state;
		next_cur         = cur;
		next_step        = step;
		next_polls       = polls;
		next_bypass_on   = bypass_on;
		next_done        = 1'b0;
		next_fail        = fail;
		next_rd_data     = rd_data;
		next_last_toggle = last_toggle;
		next_polled_once = polled_once;
		next_pins        = pins;
		tmr_load         = 1'b0;
		tmr_value        = nor_host_pkg::WRITE_LOW_CYC;
		next_pins.byte_mode_n                 = !byte_eff;
		next_pins.edge_guard_fast_program_pin = !write_guard;
		case (state)
			nor_host_pkg::ST_IDLE: begin
				next_pins.chip_sel_n = 1'b1;
				next_pins.reset_dev_n = 1'b1;
				next_pins.write_n    = 1'b1;
				next_pins.out_en_n   = 1'b1;
				next_pins.dq_oe      = 1'b0;
				if (req_valid) begin
					next_cur         = req;
					next_step        = 3'd0;
					next_fail        = 1'b0;
					next_polls       = '0;
					next_polled_once = 1'b0;
					tmr_load         = 1'b1;
					if (req.op == nor_host_pkg::OP_READ) begin
						tmr_value = nor_host_pkg::READ_ACC_CYC;
						next_state = nor_host_pkg::ST_RD;
					end else if (req.op == nor_host_pkg::OP_HW_RESET) begin
						tmr_value = nor_host_pkg::RESET_LOW_CYC;
						next_pins.reset_dev_n = 1'b0;
						next_state = nor_host_pkg::ST_RST;
					end else begin
						next_state = nor_host_pkg::ST_WR_LOW;
					end
				end
			end
			nor_host_pkg::ST_WR_LOW: begin
				next_pins.chip_sel_n = 1'b0;
				next_pins.write_n    = 1'b0;
				next_pins.out_en_n   = 1'b1;
				next_pins.dq_oe      = 1'b1;
				next_pins.addr       = (cur.op == nor_host_pkg::OP_RAW_WRITE ||
					cyc_addr == cur.addr[11:0]) ? cur.addr :
					{{(nor_host_pkg::BYTE_ADDR_W-12){1'b0}}, cyc_addr};
				next_pins.dq_out     = (cur.op == nor_host_pkg::OP_RAW_WRITE ||
					(cur.op == nor_host_pkg::OP_PROGRAM && step == steps - 3'd1)) ?
					cur.data : {8'h00, cyc_data};
				if (tmr_expired) begin
					tmr_load   = 1'b1;
					tmr_value  = nor_host_pkg::WRITE_HIGH_CYC;
					next_state = nor_host_pkg::ST_WR_HIGH;
				end
			end
			nor_host_pkg::ST_WR_HIGH: begin
				next_pins.write_n    = 1'b1;
				next_pins.chip_sel_n = 1'b1;
				if (tmr_expired) begin
					next_state = nor_host_pkg::ST_NEXT;
				end
			end
			nor_host_pkg::ST_NEXT: begin
				next_pins.dq_oe = 1'b0;
				tmr_load        = 1'b1;
				if (step + 3'd1 < steps) begin
					next_step  = step + 3'd1;
					next_state = nor_host_pkg::ST_WR_LOW;
				end else if (cur.op == nor_host_pkg::OP_PROGRAM ||
					cur.op == nor_host_pkg::OP_SECT_ERASE || cur.op == nor_host_pkg::OP_RESUME) begin
					tmr_value  = nor_host_pkg::READ_ACC_CYC;
					next_state = nor_host_pkg::ST_POLL;
				end else begin
					if (cur.op == nor_host_pkg::OP_BYPASS_ON) next_bypass_on = 1'b1;
					if (cur.op == nor_host_pkg::OP_BYPASS_OFF ||
						cur.op == nor_host_pkg::OP_SOFT_RESET) next_bypass_on = 1'b0;
					next_state = nor_host_pkg::ST_DONE;
				end
			end
			nor_host_pkg::ST_POLL: begin
				// Status reads of the busy sector until the toggle bit stops
				next_pins.chip_sel_n = 1'b0;
				next_pins.out_en_n   = 1'b0;
				next_pins.addr       = cur.addr;
				if (tmr_expired) begin
					tmr_load         = 1'b1;
					tmr_value        = nor_host_pkg::READ_ACC_CYC;
					next_polls       = polls + 16'd1;
					next_last_toggle = dq_in[6];
					next_polled_once = 1'b1;
					next_pins.out_en_n = 1'b1;
					if (polled_once && operation_idle_output &&
						dq_in[6] == last_toggle) begin
						next_rd_data = dq_in;
						next_state   = nor_host_pkg::ST_DONE;
					end else if (polled_once && !operation_idle_output && dq_in[5] &&
						dq_in[6] != last_toggle) begin
						// Timeout flag: protected sector or failure
						next_fail  = 1'b1;
						next_state = nor_host_pkg::ST_DONE;
					end else if (polls == POLL_LIMIT) begin
						next_fail  = 1'b1;
						next_state = nor_host_pkg::ST_DONE;
					end
				end
			end
			nor_host_pkg::ST_RD: begin
				next_pins.chip_sel_n = 1'b0;
				next_pins.out_en_n   = 1'b0;
				next_pins.dq_oe      = 1'b0;
				next_pins.addr       = req_valid ? cur.addr : cur.addr;
				if (tmr_expired) begin
					next_rd_data = byte_eff ? {8'h00, dq_in[7:0]} : dq_in;
					next_state   = nor_host_pkg::ST_DONE;
				end
			end
			nor_host_pkg::ST_RST: begin
				next_pins.reset_dev_n = 1'b0;
				next_pins.chip_sel_n  = 1'b1;
				if (tmr_expired) begin
					next_pins.reset_dev_n = 1'b1;
					next_bypass_on        = 1'b0;
					next_state            = nor_host_pkg::ST_DONE;
				end
			end
			nor_host_pkg::ST_DONE: begin
				next_pins.chip_sel_n = 1'b1;
				next_pins.out_en_n   = 1'b1;
				next_done            = 1'b1;
				next_state           = nor_host_pkg::ST_IDLE;
			end
			default: next_state = nor_host_pkg::ST_IDLE;
		endcase
	end

	// ****************************************
	// State registers
	// ****************************************
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state       <= nor_host_pkg::ST_IDLE;
			cur         <= '0;
			step        <= '0;
			polls       <= '0;
			bypass_on   <= 1'b0;
			done        <= 1'b0;
			fail        <= 1'b0;
			rd_data     <= '0;
			last_toggle <= 1'b0;
			polled_once <= 1'b0;
			pins        <= '{chip_sel_n: 1'b1, write_n: 1'b1, out_en_n: 1'b1,
				reset_dev_n: 1'b0, byte_mode_n: 1'b1, edge_guard_fast_program_pin: 1'b1,
				addr: '0, dq_out: '0, dq_oe: 1'b0};
		end else begin
			state       <= next_state;
			cur         <= next_cur;
			step        <= next_step;
			polls       <= next_polls;
			bypass_on   <= next_bypass_on;
			done        <= next_done;
			fail        <= next_fail;
			rd_data     <= next_rd_data;
			last_toggle <= next_last_toggle;
			polled_once <= next_polled_once;
			pins        <= next_pins;
		end
	end
endmodule : nor_host_ctrl

// ### tb/nor_host_ctrl_checker.sv
// Pin timing checker bound to the NOR flash host controller
`timescale 1ns/1ps
module nor_host_ctrl_checker #(
	parameter bit          BYTE_CAPABLE = 1'b1,
	parameter logic [15:0] POLL_LIMIT   = 16'hFFFF
) (
	input wire logic                            clk,
	input wire logic                            reset_n,
	input wire logic                            byte_mode,
	input wire logic                            write_guard,
	input wire logic                            req_valid,
	input wire logic                            req_ready,
	input wire nor_host_pkg::req_t              req,
	input wire logic                            done,
	input wire logic                            fail,
	input wire logic [nor_host_pkg::DATA_W-1:0] rd_data,
	input wire logic                            bypass_on,
	input wire nor_host_pkg::pins_t             pins,
	input wire logic [nor_host_pkg::DATA_W-1:0] dq_in,
	input wire logic                            operation_idle_output
);
	default clocking @(posedge clk);
	endclocking
	default disable iff (!reset_n);

	// ****************************************
	// Strobes and bus ownership
	// ****************************************
	property p_one_strobe;
		!(!pins.write_n && !pins.out_en_n);
	endproperty
	a_one_strobe: assert property (p_one_strobe) else $error("both strobes low");
	property p_drive_write;
		!pins.write_n |-> pins.dq_oe && !pins.chip_sel_n;
	endproperty
	a_drive_write: assert property (p_drive_write) else $error("write without drive");
	property p_free_read;
		!pins.out_en_n |-> !pins.dq_oe;
	endproperty
	a_free_read: assert property (p_free_read) else $error("drive during read");
	property p_write_len;
		$fell(pins.write_n) |-> (!pins.write_n) [*7];
	endproperty
	a_write_len: assert property (p_write_len) else $error("write strobe short");
	property p_write_hold;
		!pins.write_n && !$past(pins.write_n) |-> $stable(pins.addr) && $stable(pins.dq_out);
	endproperty
	a_write_hold: assert property (p_write_hold) else $error("write data moved");

	// ****************************************
	// Completion and mode pins
	// ****************************************
	property p_done_pulse;
		done |=> !done;
	endproperty
	a_done_pulse: assert property (p_done_pulse) else $error("done too long");
	property p_read_time;
		req_valid && req_ready && req.op == nor_host_pkg::OP_READ |-> ##[14:40] done;
	endproperty
	a_read_time: assert property (p_read_time) else $error("read completion time");
	property p_byte_pin;
		$past(reset_n) && $stable(byte_mode) |-> pins.byte_mode_n == !(byte_mode && BYTE_CAPABLE);
	endproperty
	a_byte_pin: assert property (p_byte_pin) else $error("byte pin wrong");
	property p_guard_pin;
		$past(reset_n) && $stable(write_guard) |-> pins.edge_guard_fast_program_pin == !write_guard;
	endproperty
	a_guard_pin: assert property (p_guard_pin) else $error("guard pin wrong");
	property p_reset_len;
		$fell(pins.reset_dev_n) |-> (!pins.reset_dev_n) [*8];
	endproperty
	a_reset_len: assert property (p_reset_len) else $error("reset pulse short");
endmodule : nor_host_ctrl_checker

bind nor_host_ctrl nor_host_ctrl_checker #(.BYTE_CAPABLE(BYTE_CAPABLE), .POLL_LIMIT(POLL_LIMIT)) i_chk (
	.clk(clk), .reset_n(reset_n), .byte_mode(byte_mode), .write_guard(write_guard),
	.req_valid(req_valid), .req_ready(req_ready), .req(req), .done(done), .fail(fail),
	.rd_data(rd_data), .bypass_on(bypass_on), .pins(pins), .dq_in(dq_in),
	.operation_idle_output(operation_idle_output)
);

// ### tb/nor_flash_model.sv
// Behavioural model of the NOR flash behind the controller pins
`timescale 1ns/1ps
module nor_flash_model #(
	parameter int BUSY_CYC   = 80,
	parameter int SECT_SHIFT = 16
) (
	input wire nor_host_pkg::pins_t pins,
	output logic [15:0]             dq_in,
	output logic                    operation_idle_output
);
	logic [15:0] mem [int];
	int          ks [$];
	logic [15:0] rdv;
	logic [15:0] w;
	logic [15:0] last  = 16'h0000;
	logic [15:0] ld;
	logic [15:0] pd;
	logic [22:0] la;
	logic [22:0] pa;
	logic        lcs   = 1'b1;
	logic        busy  = 1'b0;
	logic        ejob  = 1'b0;
	logic        byp   = 1'b0;
	logic        ers   = 1'b0;
	logic        tog   = 1'b0;
	logic        drv;
	int          step  = 0;
	int          left  = 0;

	// Array word, erased where never written
	function automatic logic [15:0] word_at(input int k);
		return mem.exists(k) ? mem[k] : 16'hFFFF;
	endfunction : word_at

	task automatic start(input logic erase);
		pa = la;
		pd = ld;
		ejob = erase;
		left = BUSY_CYC;
		busy = 1'b1;
	endtask : start

	// Latch address and data while the write strobe is low
	always @(pins) begin
		if (!pins.write_n) begin
			la = pins.addr;
			ld = pins.dq_out;
			lcs = pins.chip_sel_n;
		end
	end

	// Command decoder on the rising write strobe
	always @(posedge pins.write_n) begin
		if (!lcs && pins.reset_dev_n && !busy) begin
			case (step)
				0: step = byp && ld[7:0] == nor_host_pkg::CMD_PROGRAM ? 3 :
					byp && ld[7:0] == nor_host_pkg::CMD_BYPASS_EX ? 5 :
					ld[7:0] == nor_host_pkg::UNLOCK_DATA_A ? 1 : 0;
				1: step = ld[7:0] == nor_host_pkg::UNLOCK_DATA_B ? 2 : 0;
				2: begin
					if (ers && ld[7:0] == nor_host_pkg::CMD_SECT_ERS) start(1'b1);
					ers = ld[7:0] == nor_host_pkg::CMD_ERASE_SET;
					byp = byp | (ld[7:0] == nor_host_pkg::CMD_BYPASS_EN);
					step = ld[7:0] == nor_host_pkg::CMD_PROGRAM ? 3 : 0;
				end
				3: begin
					start(1'b0);
					step = 0;
				end
				5: begin
					byp = 1'b0;
					step = 0;
				end
				default: step = 0;
			endcase
		end
	end

	// Embedded operation timer and array update
	always #5 begin
		if (busy && left > 0) left--;
		else if (busy) begin
			busy = 1'b0;
			if (pins.edge_guard_fast_program_pin || (pa >> SECT_SHIFT) != 0) begin
				if (!ejob) mem[pa] = word_at(pa) & pd;
				else foreach (mem[k]) if ((k >> SECT_SHIFT) == int'(pa >> SECT_SHIFT)) ks.push_back(k);
				foreach (ks[i]) mem.delete(ks[i]);
				ks.delete();
			end
		end
	end

	// Hardware reset aborts everything
	always @(negedge pins.reset_dev_n) begin
		busy = 1'b0;
		step = 0;
		byp = 1'b0;
		ers = 1'b0;
	end

	// Read path: status while busy, array otherwise
	always @(negedge pins.out_en_n) tog = tog ^ busy;
	always @(pins, busy, tog) begin
		w = word_at(pins.byte_mode_n ? int'(pins.addr) : int'(pins.addr >> 1));
		if (busy) rdv = {8'h00, ~pd[7] & ~ejob, tog, 6'h00};
		else if (!pins.byte_mode_n) rdv = {8'hA5, pins.addr[0] ? w[15:8] : w[7:0]};
		else rdv = w;
	end
	always @(negedge drv) last = rdv;
	assign drv = !pins.chip_sel_n && !pins.out_en_n && pins.reset_dev_n;
	assign dq_in = drv ? rdv : pins.dq_oe ? pins.dq_out : ~last;
	assign operation_idle_output = !busy;
endmodule : nor_flash_model

// ### tb/parallel_nor_flash_control_bench.sv
// Self-checking bench for the NOR flash host controller
`timescale 1ns/1ps
module parallel_nor_flash_control_bench;
	logic                clk;
	logic                reset_n;
	logic                byte_mode;
	logic                write_guard;
	logic                req_valid;
	logic                req_ready;
	nor_host_pkg::req_t  req;
	logic                done;
	logic                fail;
	logic [15:0]         rd_data;
	logic                bypass_on;
	nor_host_pkg::pins_t pins;
	logic [15:0]         dq_in;
	logic                idle;
	int                  bad_count;
	int                  n_compared;
	int                  n_wr;

	// ****************************************
	// Clock and instances
	// ****************************************
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	nor_host_ctrl #(.BYTE_CAPABLE(1'b1), .POLL_LIMIT(16'h0040)) i_nor_host_ctrl (
		.clk(clk), .reset_n(reset_n), .byte_mode(byte_mode), .write_guard(write_guard),
		.req_valid(req_valid), .req_ready(req_ready), .req(req), .done(done), .fail(fail),
		.rd_data(rd_data), .bypass_on(bypass_on), .pins(pins), .dq_in(dq_in),
		.operation_idle_output(idle)
	);
	nor_flash_model i_nor_flash_model (.pins(pins), .dq_in(dq_in), .operation_idle_output(idle));
	always @(negedge pins.write_n) n_wr++;

	// ****************************************
	// Shared tasks
	// ****************************************
	task test_done;
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : test_done

	task chk(input string what, input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	// One request, waiting for its done pulse
	task op(input nor_host_pkg::op_t o, input logic [22:0] a, input logic [15:0] d);
		int i;
		@(negedge clk);
		n_wr = 0;
		req_valid = 1'b1;
		req = '{o, a, d};
		for (i = 0; i < 200 && req_ready !== 1'b1; i++) @(negedge clk);
		if (i == 200) begin
			bad_count++;
			test_done();
		end
		@(negedge clk);
		req_valid = 1'b0;
		for (i = 0; i < 4000 && done !== 1'b1; i++) @(negedge clk);
		if (i == 4000) begin
			bad_count++;
			test_done();
		end
	endtask : op

	// ****************************************
	// Scenarios
	// ****************************************
	task t_program;
		op(nor_host_pkg::OP_READ, 23'h100010, 16'h0000);
		chk("blank word", rd_data, 16'hFFFF);
		chk("standby select", {15'h0, pins.chip_sel_n}, 16'h0001);
		op(nor_host_pkg::OP_PROGRAM, 23'h100010, 16'h1234);
		chk("program strobes", n_wr[15:0], 16'h0004);
		chk("program fail", {15'h0, fail}, 16'h0000);
		op(nor_host_pkg::OP_READ, 23'h100010, 16'h0000);
		chk("program readback", rd_data, 16'h1234);
	endtask : t_program

	task t_bypass;
		op(nor_host_pkg::OP_BYPASS_ON, 23'h000000, 16'h0000);
		chk("bypass on", {15'h0, bypass_on}, 16'h0001);
		op(nor_host_pkg::OP_PROGRAM, 23'h100020, 16'hABCD);
		chk("bypass strobes", n_wr[15:0], 16'h0002);
		op(nor_host_pkg::OP_READ, 23'h100020, 16'h0000);
		chk("bypass readback", rd_data, 16'hABCD);
		op(nor_host_pkg::OP_BYPASS_OFF, 23'h000000, 16'h0000);
		chk("bypass off", {15'h0, bypass_on}, 16'h0000);
	endtask : t_bypass

	task t_erase;
		op(nor_host_pkg::OP_PROGRAM, 23'h200000, 16'h5555);
		op(nor_host_pkg::OP_SECT_ERASE, 23'h100000, 16'h0000);
		chk("erase fail", {15'h0, fail}, 16'h0000);
		op(nor_host_pkg::OP_READ, 23'h100010, 16'h0000);
		chk("erased sector", rd_data, 16'hFFFF);
		op(nor_host_pkg::OP_READ, 23'h200000, 16'h0000);
		chk("other sector", rd_data, 16'h5555);
	endtask : t_erase

	task t_guard_byte;
		write_guard = 1'b1;
		op(nor_host_pkg::OP_PROGRAM, 23'h000004, 16'h0000);
		op(nor_host_pkg::OP_READ, 23'h000004, 16'h0000);
		chk("guarded sector", rd_data, 16'hFFFF);
		write_guard = 1'b0;
		byte_mode = 1'b1;
		op(nor_host_pkg::OP_READ, 23'h300001, 16'h0000);
		chk("byte read", rd_data, 16'h00FF);
		byte_mode = 1'b0;
	endtask : t_guard_byte

	task t_reset_misc;
		nor_host_pkg::op_t ops [4];
		ops = '{nor_host_pkg::OP_SOFT_RESET, nor_host_pkg::OP_SUSPEND,
			nor_host_pkg::OP_RESUME, nor_host_pkg::OP_RAW_WRITE};
		foreach (ops[k]) begin
			op(ops[k], 23'h000555, 16'h00F0);
			chk("command strobes", {15'h0, n_wr != 0}, 16'h0001);
		end
		op(nor_host_pkg::OP_HW_RESET, 23'h000000, 16'h0000);
		chk("reset released", {15'h0, pins.reset_dev_n}, 16'h0001);
		op(nor_host_pkg::OP_READ, 23'h200000, 16'h0000);
		chk("read after reset", rd_data, 16'h5555);
	endtask : t_reset_misc

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		reset_n = 1'b0;
		byte_mode = 1'b0;
		write_guard = 1'b0;
		req_valid = 1'b0;
		req = '0;
		bad_count = 0;
		n_compared = 0;
		n_wr = 0;
		repeat (2) @(negedge clk);
		reset_n = 1'b1;
		t_program();
		t_bypass();
		t_erase();
		t_guard_byte();
		t_reset_misc();
		test_done();
	end
endmodule : parallel_nor_flash_control_bench
